// File: rtl/cpss_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module cpss_top #(
  parameter int unsigned FRAME_CYCLES = cpss_pkg::FRAME_8K_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        FRAME_SYNC_IN_FIRST,
  input  wire logic        FRAME_SYNC_IN_SECOND,
  input  wire logic        FRAME_SYNC_IN_THIRD,
  input  wire logic        SE_OUT_STRAP_BIT1,
  input  wire logic        SE_OUT_STRAP_BIT2,
  input  wire logic [2:0]  DIFF_OUT_FREQ_STRAP,
  input  wire logic [3:0]  SELECTED_REF,
  output logic [4:0]       SYNC_ROUTE,
  output logic [2:0]       SE_OUT_FREQ_SEL,
  output logic [2:0]       DIFF_OUT_FREQ_SEL,
  output logic [1:0]       DIFF_OUT_FORMAT,
  output logic [19:0]      IN_FREQ_CFG,
  output logic             FRAME_PULSE_8K_OUT,
  output logic             MULTIFRAME_PULSE_2K_OUT,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  localparam logic [16:0] FRAME_LAST = 17'(FRAME_CYCLES - 1);
  localparam logic [16:0] FRAME_HALF = 17'(FRAME_CYCLES / 2);

  cpss_pkg::cpss_state_type s;
  cpss_pkg::cpss_state_type next_s;

  logic        src_paired;
  logic        aux_paired;
  logic        first_hi;
  logic        second_hi;
  logic [4:0]  next_route;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  logic        do_write;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Frame-sync association
  always_comb begin
    src_paired = s.source[3:2] == cpss_pkg::PAIRED_PATTERN;
    aux_paired = s.aux_source[3:2] == cpss_pkg::PAIRED_PATTERN;
    case (s.shape[cpss_pkg::SHAPE_PAIR_LSB +: 2])
      cpss_pkg::PAIR_FORCE_LO: begin
        first_hi  = 1'b0;
        second_hi = 1'b0;
      end
      cpss_pkg::PAIR_FORCE_HI: begin
        first_hi  = 1'b1;
        second_hi = 1'b1;
      end
      cpss_pkg::PAIR_FOLLOW_HI: begin
        first_hi  = SELECTED_REF != cpss_pkg::REF_A;
        second_hi = SELECTED_REF != cpss_pkg::REF_B;
      end
      default: begin
        first_hi  = SELECTED_REF == cpss_pkg::REF_C;
        second_hi = SELECTED_REF == cpss_pkg::REF_D;
      end
    endcase
    next_route = 5'h00;
    if (!src_paired) begin
      if (s.source <= cpss_pkg::REF_E) begin
        next_route[s.source[2:0]] = FRAME_SYNC_IN_FIRST;
      end
    end else begin
      next_route[first_hi ? 2 : 0]  = FRAME_SYNC_IN_FIRST;
      next_route[second_hi ? 3 : 1] = FRAME_SYNC_IN_SECOND;
    end
    if (aux_paired) begin
      next_route[4] = next_route[4] | FRAME_SYNC_IN_THIRD;
    end
  end

  // Register read decode
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR)
      cpss_pkg::OFF_SOURCE:  rd_word[3:0] = s.source;
      cpss_pkg::OFF_AUX:     rd_word[3:0] = s.aux_source;
      cpss_pkg::OFF_SHAPE:   rd_word[7:0] = s.shape;
      cpss_pkg::OFF_MASTER8: rd_word[1:0] = s.diff_format;
      cpss_pkg::OFF_OUTFREQ: begin
        rd_word[cpss_pkg::FREQ_SE_LSB +: 3]   = s.se_freq;
        rd_word[cpss_pkg::FREQ_DIFF_LSB +: 3] = s.diff_freq;
      end
      cpss_pkg::OFF_STRAP: begin
        rd_word[cpss_pkg::FREQ_SE_LSB +: 3]   = s.se_strap;
        rd_word[cpss_pkg::FREQ_DIFF_LSB +: 3] = s.diff_strap;
      end
      cpss_pkg::OFF_INFREQ:  rd_word[19:0] = s.in_freq;
      cpss_pkg::OFF_ROUTE:   rd_word[4:0] = s.route;
      default:               rd_hit = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    logic [31:0] w;
    w        = 32'h0000_0000;
    next_s   = s;
    do_write = s.aw_full && s.w_full && !s.bvalid;
    wr_hit   = 1'b1;
    if (RESET) begin
      next_s             = '0;
      next_s.rst_d       = 1'b1;
      next_s.se_strap    = cpss_pkg::SE_FREQ_RST;
      next_s.diff_strap  = cpss_pkg::DIFF_FREQ_RST;
      next_s.source      = cpss_pkg::SOURCE_RST;
      next_s.aux_source  = cpss_pkg::AUX_RST;
      next_s.shape       = cpss_pkg::SHAPE_RST;
      next_s.diff_format = cpss_pkg::FORMAT_RST;
      next_s.se_freq     = cpss_pkg::SE_FREQ_RST;
      next_s.diff_freq   = cpss_pkg::DIFF_FREQ_RST;
      next_s.in_freq     = cpss_pkg::IN_FREQ_RST;
    end else begin
      next_s.rst_d = 1'b0;
      if (s.rst_d) begin
        next_s.se_strap   = {SE_OUT_STRAP_BIT2, SE_OUT_STRAP_BIT1, FRAME_SYNC_IN_THIRD};
        next_s.diff_strap = DIFF_OUT_FREQ_STRAP;
        next_s.se_freq    = {SE_OUT_STRAP_BIT2, SE_OUT_STRAP_BIT1, FRAME_SYNC_IN_THIRD};
        next_s.diff_freq  = DIFF_OUT_FREQ_STRAP;
      end
      next_s.route = next_route;
      if (s.frame_cnt >= FRAME_LAST) begin
        next_s.frame_cnt = 17'h00000;
        next_s.mf_cnt    = s.mf_cnt + 2'h1;
      end else begin
        next_s.frame_cnt = s.frame_cnt + 17'h00001;
      end
      next_s.fp8 = s.shape[cpss_pkg::SHAPE_INV8_BIT] ^
                   (s.shape[cpss_pkg::SHAPE_PUL8_BIT] ? s.frame_cnt == 17'h00000
                                                      : s.frame_cnt < FRAME_HALF);
      next_s.mf2 = s.shape[cpss_pkg::SHAPE_INV2_BIT] ^
                   (s.shape[cpss_pkg::SHAPE_PUL2_BIT]
                    ? (s.frame_cnt == 17'h00000 && s.mf_cnt == 2'h0)
                    : s.mf_cnt < cpss_pkg::MF_HALF);
      if (S_AXI_AWVALID && s.awready) begin
        next_s.aw_full = 1'b1;
        next_s.awaddr  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s.wready) begin
        next_s.w_full = 1'b1;
        next_s.wdata  = S_AXI_WDATA;
        next_s.wstrb  = S_AXI_WSTRB;
      end
      if (do_write) begin
        case (s.awaddr)
          cpss_pkg::OFF_SOURCE: begin
            w             = merge({28'h0000000, s.source}, s.wdata, s.wstrb);
            next_s.source = w[3:0];
          end
          cpss_pkg::OFF_AUX: begin
            w                 = merge({28'h0000000, s.aux_source}, s.wdata, s.wstrb);
            next_s.aux_source = w[3:0];
          end
          cpss_pkg::OFF_SHAPE: begin
            w            = merge({24'h000000, s.shape}, s.wdata, s.wstrb);
            next_s.shape = w[7:0];
          end
          cpss_pkg::OFF_MASTER8: begin
            w                  = merge({30'h00000000, s.diff_format}, s.wdata, s.wstrb);
            next_s.diff_format = w[1:0];
          end
          cpss_pkg::OFF_OUTFREQ: begin
            w                = merge({25'h0000000, s.diff_freq, 1'b0, s.se_freq},
                                     s.wdata, s.wstrb);
            next_s.se_freq   = w[cpss_pkg::FREQ_SE_LSB +: 3];
            next_s.diff_freq = w[cpss_pkg::FREQ_DIFF_LSB +: 3];
          end
          cpss_pkg::OFF_INFREQ: begin
            w              = merge({12'h000, s.in_freq}, s.wdata, s.wstrb);
            next_s.in_freq = w[19:0];
          end
          cpss_pkg::OFF_STRAP, cpss_pkg::OFF_ROUTE: wr_hit = 1'b1;
          default: wr_hit = 1'b0;
        endcase
        next_s.aw_full = 1'b0;
        next_s.w_full  = 1'b0;
        next_s.bvalid  = 1'b1;
        next_s.bresp   = wr_hit ? cpss_pkg::RESP_OKAY : cpss_pkg::RESP_SLVERR;
      end else if (s.bvalid && S_AXI_BREADY) begin
        next_s.bvalid = 1'b0;
      end
      next_s.awready = !next_s.aw_full;
      next_s.wready  = !next_s.w_full;
      if (S_AXI_ARVALID && s.arready) begin
        next_s.arready = 1'b0;
        next_s.rvalid  = 1'b1;
        next_s.rdata   = rd_word;
        next_s.rresp   = rd_hit ? cpss_pkg::RESP_OKAY : cpss_pkg::RESP_SLVERR;
      end else if (s.rvalid && S_AXI_RREADY) begin
        next_s.rvalid  = 1'b0;
        next_s.arready = 1'b1;
      end else if (!s.rvalid) begin
        next_s.arready = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    s <= next_s;
  end

  assign SYNC_ROUTE              = s.route;
  assign SE_OUT_FREQ_SEL         = s.se_freq;
  assign DIFF_OUT_FREQ_SEL       = s.diff_freq;
  assign DIFF_OUT_FORMAT         = s.diff_format;
  assign IN_FREQ_CFG             = s.in_freq;
  assign FRAME_PULSE_8K_OUT      = s.fp8;
  assign MULTIFRAME_PULSE_2K_OUT = s.mf2;
  assign S_AXI_AWREADY           = s.awready;
  assign S_AXI_WREADY            = s.wready;
  assign S_AXI_BVALID            = s.bvalid;
  assign S_AXI_BRESP             = s.bresp;
  assign S_AXI_ARREADY           = s.arready;
  assign S_AXI_RVALID            = s.rvalid;
  assign S_AXI_RDATA             = s.rdata;
  assign S_AXI_RRESP             = s.rresp;

  // Checks
  sequence release_seq;
    s.rst_d && !RESET;
  endsequence

  sequence steady_seq;
    !s.rst_d && !RESET;
  endsequence

  strap_capture_a: assert property (@(posedge CLK) disable iff (RESET)
    release_seq |=> s.se_strap == {$past(SE_OUT_STRAP_BIT2), $past(SE_OUT_STRAP_BIT1),
                                   $past(FRAME_SYNC_IN_THIRD)})
    else $error("Single-ended strap not captured at release");

  diff_default_a: assert property (@(posedge CLK) disable iff (RESET)
    release_seq |=> s.diff_freq == $past(DIFF_OUT_FREQ_STRAP) && s.diff_strap == s.diff_freq)
    else $error("Differential default not taken from strap");

  se_default_a: assert property (@(posedge CLK) disable iff (RESET)
    release_seq |=> SE_OUT_FREQ_SEL == {$past(SE_OUT_STRAP_BIT2), $past(SE_OUT_STRAP_BIT1),
                                        $past(FRAME_SYNC_IN_THIRD)})
    else $error("Single-ended default not taken from strap");

  strap_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    steady_seq |=> $stable(s.se_strap) && $stable(s.diff_strap))
    else $error("Captured strap changed after release");

  first_named_a: assert property (@(posedge CLK) disable iff (RESET)
    (s.source == cpss_pkg::REF_A) |=> SYNC_ROUTE[0] == $past(FRAME_SYNC_IN_FIRST))
    else $error("First sync not routed to named input");

  second_ignored_a: assert property (@(posedge CLK) disable iff (RESET)
    (!src_paired && s.source != cpss_pkg::REF_B && s.source != cpss_pkg::REF_D)
    |=> !SYNC_ROUTE[1] && !SYNC_ROUTE[3])
    else $error("Second sync used while source not paired");

  pair_force_a: assert property (@(posedge CLK) disable iff (RESET)
    (src_paired && s.shape[1:0] == cpss_pkg::PAIR_FORCE_HI)
    |=> SYNC_ROUTE[2] == $past(FRAME_SYNC_IN_FIRST) && !SYNC_ROUTE[0])
    else $error("First sync not paired with input C");

  third_gate_a: assert property (@(posedge CLK) disable iff (RESET)
    (!aux_paired && s.source != cpss_pkg::REF_E) |=> !SYNC_ROUTE[4])
    else $error("Third sync used while aux source not paired");

  frame_clock_a: assert property (@(posedge CLK) disable iff (RESET)
    (s.frame_cnt == 17'h00000 && s.shape[5:4] == 2'h0) |=> FRAME_PULSE_8K_OUT)
    else $error("8kHz clock not high at frame start");

  frame_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
    (s.frame_cnt == 17'h00001 && s.shape[5:4] == 2'h2) |=> !FRAME_PULSE_8K_OUT)
    else $error("8kHz pulse wider than one cycle");

  multiframe_a: assert property (@(posedge CLK) disable iff (RESET)
    (s.mf_cnt == cpss_pkg::MF_LAST && s.shape[7:6] == 2'h0) |=> !MULTIFRAME_PULSE_2K_OUT)
    else $error("2kHz clock high in last quarter");

  infreq_reset_a: assert property (@(posedge CLK)
    s.rst_d |-> IN_FREQ_CFG == cpss_pkg::IN_FREQ_RST)
    else $error("Input frequency defaults wrong after reset");
endmodule : cpss_top

// File: common/cpss_pkg.sv
// Contract
// - Non-paired source: first sync serves named input
// - Paired source: first sync pairs A or C
// - Non-paired source: second sync is ignored
// - Paired source: second sync pairs B or D
// - Reset release captures shared third-sync pin bit0
// - Third sync pairs E only when aux paired
// - Single-ended default frequency from straps, open 19.44MHz
// - Differential default frequency from straps, open 38.88MHz
// - Differential output mode from format field
// - 8kHz output: 50% clock, invert and pulse options
// - 2kHz output: 50% clock, invert and pulse options
// - Inputs A and B expect 8kHz after reset
// - Inputs C, D, E expect 19.44MHz after reset
// - Reset release captures single-ended strap bits 1, 2
// - Reset release captures three differential strap bits
// - Reset returns all state to defaults
package cpss_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 4;
  localparam int unsigned FRAME_8K_PERIOD_NS = 125000;
  localparam int unsigned FRAME_8K_CYCLES    = FRAME_8K_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  MF_LAST            = 2'h3;
  localparam logic [1:0]  MF_HALF            = 2'h2;

  localparam logic [7:0] OFF_SOURCE  = 8'h00;
  localparam logic [7:0] OFF_AUX     = 8'h04;
  localparam logic [7:0] OFF_SHAPE   = 8'h08;
  localparam logic [7:0] OFF_MASTER8 = 8'h0C;
  localparam logic [7:0] OFF_OUTFREQ = 8'h10;
  localparam logic [7:0] OFF_STRAP   = 8'h14;
  localparam logic [7:0] OFF_INFREQ  = 8'h18;
  localparam logic [7:0] OFF_ROUTE   = 8'h1C;

  localparam int unsigned SHAPE_PAIR_LSB = 0;
  localparam int unsigned SHAPE_INV8_BIT = 4;
  localparam int unsigned SHAPE_PUL8_BIT = 5;
  localparam int unsigned SHAPE_INV2_BIT = 6;
  localparam int unsigned SHAPE_PUL2_BIT = 7;
  localparam int unsigned FREQ_SE_LSB    = 0;
  localparam int unsigned FREQ_DIFF_LSB  = 4;

  localparam logic [1:0] PAIRED_PATTERN = 2'h3;
  localparam logic [3:0] REF_A          = 4'h0;
  localparam logic [3:0] REF_B          = 4'h1;
  localparam logic [3:0] REF_C          = 4'h2;
  localparam logic [3:0] REF_D          = 4'h3;
  localparam logic [3:0] REF_E          = 4'h4;
  localparam logic [1:0] PAIR_FOLLOW_LO = 2'h0;
  localparam logic [1:0] PAIR_FORCE_LO  = 2'h1;
  localparam logic [1:0] PAIR_FORCE_HI  = 2'h2;
  localparam logic [1:0] PAIR_FOLLOW_HI = 2'h3;

  localparam logic [2:0]  SE_FREQ_RST   = 3'h3;
  localparam logic [2:0]  DIFF_FREQ_RST = 3'h4;
  localparam logic [3:0]  IN_FREQ_8K    = 4'h1;
  localparam logic [3:0]  IN_FREQ_19M44 = 4'h7;
  localparam logic [19:0] IN_FREQ_RST   = {IN_FREQ_19M44, IN_FREQ_19M44, IN_FREQ_19M44,
                                           IN_FREQ_8K, IN_FREQ_8K};
  localparam logic [3:0]  SOURCE_RST    = 4'h0;
  localparam logic [3:0]  AUX_RST       = 4'h0;
  localparam logic [7:0]  SHAPE_RST     = 8'h00;
  localparam logic [1:0]  FORMAT_RST    = 2'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic        rst_d;
    logic [2:0]  se_strap;
    logic [2:0]  diff_strap;
    logic [3:0]  source;
    logic [3:0]  aux_source;
    logic [7:0]  shape;
    logic [1:0]  diff_format;
    logic [2:0]  se_freq;
    logic [2:0]  diff_freq;
    logic [19:0] in_freq;
    logic [16:0] frame_cnt;
    logic [1:0]  mf_cnt;
    logic        fp8;
    logic        mf2;
    logic [4:0]  route;
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cpss_state_type;
endpackage : cpss_pkg

// File: sim/cpss_sync_src.sv
`timescale 1ns/1ns
module cpss_sync_src #(
  parameter int unsigned FRAME_CYCLES = 16
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  input  wire logic [2:0] lvl,
  output logic      [2:0] sync
);
  int unsigned cnt;
  logic [1:0]  rsel;
  always_ff @(posedge clk) begin
    if (reset || cnt == FRAME_CYCLES * 4 - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Sync pulses at 8k, 4k or 2k only
  always_comb begin
    rsel = (rate > 2'h2) ? 2'h2 : rate;
    if (run) begin
      sync = {3{cnt % (FRAME_CYCLES << rsel) == 0}};
    end else begin
      sync = lvl;
    end
  end
endmodule : cpss_sync_src

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned FC = 16;
  logic        clk, reset, se1, se2, run, awvalid, wvalid, bready, arvalid, rready;
  logic        fp8, mf2, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  rate, resp, bresp, rresp, fmt;
  logic [2:0]  lvl, diff, sync, se_sel, diff_sel;
  logic [3:0]  sel, wstrb;
  logic [4:0]  route, er;
  logic [7:0]  awaddr, araddr;
  logic [19:0] infreq;
  logic [31:0] wdata, rd, rdata, n8, n2, nr, e8, e2;
  logic [7:0]  shapes [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80, 8'hC0};
  int          error_cnt, check_count, cyc;

  cpss_top #(.FRAME_CYCLES(FC)) dut_u (
    .CLK(clk), .RESET(reset), .FRAME_SYNC_IN_FIRST(sync[0]),
    .FRAME_SYNC_IN_SECOND(sync[1]), .FRAME_SYNC_IN_THIRD(sync[2]),
    .SE_OUT_STRAP_BIT1(se1), .SE_OUT_STRAP_BIT2(se2), .DIFF_OUT_FREQ_STRAP(diff),
    .SELECTED_REF(sel), .SYNC_ROUTE(route), .SE_OUT_FREQ_SEL(se_sel),
    .DIFF_OUT_FREQ_SEL(diff_sel), .DIFF_OUT_FORMAT(fmt), .IN_FREQ_CFG(infreq),
    .FRAME_PULSE_8K_OUT(fp8), .MULTIFRAME_PULSE_2K_OUT(mf2),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  cpss_sync_src #(.FRAME_CYCLES(FC)) src_u (
    .clk(clk), .reset(reset), .run(run), .rate(rate), .lvl(lvl), .sync(sync));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do @(negedge clk); while (!bvalid);
    resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd   = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rdr

  task automatic do_reset(input logic b0, input logic b1, input logic b2, input logic [2:0] d);
    @(posedge clk);
    reset <= 1'b1;
    lvl   <= {b0, 2'b00};
    se1   <= b1;
    se2   <= b2;
    diff  <= d;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : do_reset

  function automatic logic [4:0] exp_rt(logic [3:0] s, logic [3:0] x, logic [1:0] p,
                                        logic [3:0] r, logic [2:0] l);
    logic [4:0] e;
    logic       h1, h2;
    e  = 5'h00;
    h1 = (p == 2'h2) || (p == 2'h0 && r == cpss_pkg::REF_C) || (p == 2'h3 && r != cpss_pkg::REF_A);
    h2 = (p == 2'h2) || (p == 2'h0 && r == cpss_pkg::REF_D) || (p == 2'h3 && r != cpss_pkg::REF_B);
    if (s[3:2] == 2'h3) begin
      e[h1 ? 2 : 0] = l[0];
      e[h2 ? 3 : 1] = l[1];
    end else if (s < 4'h5) begin
      e[s[2:0]] = l[0];
    end
    if (x[3:2] == 2'h3) e[4] = l[2];
    return e;
  endfunction : exp_rt

  initial begin
    reset       = 1'b1;
    se1         = 1'b0;
    se2         = 1'b0;
    run         = 1'b0;
    rate        = 2'h0;
    lvl         = 3'h0;
    diff        = 3'h0;
    sel         = 4'h0;
    wstrb       = 4'hF;
    awvalid     = 1'b0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    awaddr      = 8'h00;
    araddr      = 8'h00;
    wdata       = 32'h0000_0000;
    error_cnt   = 0;
    check_count = 0;
    cyc         = 0;
    do_reset(1'b1, 1'b1, 1'b0, 3'h4);
    chk(32'(se_sel), 32'h0000_0003);
    chk(32'(diff_sel), 32'h0000_0004);
    chk(32'(infreq), 32'h0007_7711);
    chk(32'(route), 32'h0000_0000);
    do_reset(1'b0, 1'b0, 1'b1, 3'h3);
    @(posedge clk);
    lvl  <= 3'h4;
    se1  <= 1'b1;
    se2  <= 1'b0;
    diff <= 3'h4;
    repeat (4) @(negedge clk);
    chk(32'(se_sel), 32'h0000_0004);
    chk(32'(diff_sel), 32'h0000_0003);
    rdr(8'h14);
    chk(rd, 32'h0000_0034);
    wr(8'h14, 32'h0000_0000);
    rdr(8'h14);
    chk(rd, 32'h0000_0034);
    wr(8'h10, 32'h0000_0025);
    @(negedge clk);
    chk(32'({se_sel, diff_sel}), 32'h0000_002A);
    wr(8'h18, 32'h0001_2345);
    @(negedge clk);
    chk(32'(infreq), 32'h0001_2345);
    rdr(8'h18);
    chk(rd, 32'h0001_2345);
    @(posedge clk);
    wstrb <= 4'h1;
    wr(8'h18, 32'h000F_FFFF);
    @(posedge clk);
    wstrb <= 4'hF;
    @(negedge clk);
    chk(32'(infreq), 32'h0001_23FF);
    for (int f = 0; f < 4; f++) begin
      wr(8'h0C, 32'(f));
      @(negedge clk);
      chk(32'(fmt), 32'(f));
    end
    wr(8'h24, 32'h0000_0001);
    chk(32'(resp), 32'h0000_0002);
    rdr(8'h20);
    chk(rd, 32'h0000_0000);
    chk(32'(resp), 32'h0000_0002);
    do_reset(1'b1, 1'b1, 1'b0, 3'h4);
    chk(32'({infreq, fmt}), 32'h001D_DC44);
    rdr(8'h10);
    chk(rd, 32'h0000_0043);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      run  <= 1'b1;
      rate <= 2'(i % 3);
      wr(8'h08, {24'h000000, shapes[i]});
      repeat (4) @(negedge clk);
      n8 = 32'h0000_0000;
      n2 = 32'h0000_0000;
      nr = 32'h0000_0000;
      repeat (64) begin
        @(negedge clk);
        n8 = n8 + fp8;
        n2 = n2 + mf2;
        nr = nr + route[0];
      end
      e8 = shapes[i][5] ? 4 : 32;
      e2 = shapes[i][7] ? 1 : 32;
      chk(n8, shapes[i][4] ? 64 - e8 : e8);
      chk(n2, shapes[i][6] ? 64 - e2 : e2);
      chk(nr, 4 >> (i % 3));
    end
    @(posedge clk);
    run <= 1'b0;
    for (int l = 0; l < 2; l++) begin
      for (int s = 0; s < 16; s++) begin
        for (int p = 0; p < 4; p++) begin
          @(posedge clk);
          lvl <= (l == 1) ? 3'h2 : 3'h7;
          wr(8'h00, 32'(s));
          wr(8'h04, 32'(s ^ 12));
          wr(8'h08, 32'(p));
          for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            sel <= 4'(r);
            repeat (3) @(negedge clk);
            er = exp_rt(4'(s), 4'(s ^ 12), 2'(p), 4'(r), lvl);
            chk(32'(route), 32'(er));
          end
        end
      end
    end
    tally_and_finish();
  end
endmodule : tb_top
